// ===== verilog/dfm_fault_manager.sv
// fault and warning manager with clear gating, history and axi4-lite registers
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "dfm_defines.svh"

module dfm_fault_manager #(
    parameter int HIST_DEPTH  = 5,
    parameter int STATUS_BITS = 16
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    ce_i,
    // event sources
    input  wire dfm_pkg::dfm_event_t     event_i,
    input  wire logic                    cause_active_i,
    input  wire logic                    mem_fail_i,
    input  wire logic                    param_check_fail_i,
    input  wire logic                    adc_ref_bad_i,
    input  wire logic [STATUS_BITS-1:0]  drive_status_i,
    // servo side
    input  wire logic                    servo_enable_i,
    input  wire logic                    clear_input_function_i,
    output logic [2:0]                   drive_state_o,
    output logic                         irq_o,
    // axi4-lite slave
    input  wire logic [11:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [11:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    import dfm_pkg::*;

    initial begin
        if (HIST_DEPTH < 1 || HIST_DEPTH > 8 || STATUS_BITS < 1 || STATUS_BITS > 24) begin
            $error("dfm_fault_manager: unsupported parameter values");
        end
        // history words must stay inside the 12-bit register window
        if (int'(`DFM_OFF_HIST_BASE) + 8 * HIST_DEPTH > 4096) begin
            $error("dfm_fault_manager: history does not fit the register window");
        end
    end

    dfm_state_t          state;
    logic [7:0]          active_fault_monitor;
    dfm_grade_t          fault_grade;
    logic [7:0]          active_warning_monitor;
    logic                fault_clear_setting;
    logic [7:0]          f_code [HIST_DEPTH];
    logic [STATUS_BITS-1:0] f_stat [HIST_DEPTH];
    logic [7:0]          w_code [HIST_DEPTH];
    logic [STATUS_BITS-1:0] w_stat [HIST_DEPTH];
    logic [3:0]          irq_stat;
    logic [3:0]          irq_mask;
    dfm_event_t          ev;
    logic                clear_req;
    logic                fault_clr_ok;
    logic                warn_clr_ok;
    logic                new_fault;
    logic                new_warn;
    logic [3:0]          irq_set;

    // internal detectors take priority over external events; the last one in code order wins
    // memory fault code
    always_comb begin
        ev = event_i;
        if (adc_ref_bad_i) begin
            ev = '{valid: 1'b1, grade: DFM_GRADE_1, code: `DFM_CODE_ADC_REF};
        end
        if (param_check_fail_i) begin
            ev = '{valid: 1'b1, grade: DFM_GRADE_1, code: `DFM_CODE_PARAM_CHK};
        end
        if (mem_fail_i) begin
            ev = '{valid: 1'b1, grade: DFM_GRADE_1, code: `DFM_CODE_PARAM_IO};
        end
    end

    assign new_warn  = ev.valid && ev.grade == DFM_GRADE_4;
    // a held fault is not displaced by a lesser one
    assign new_fault = ev.valid && ev.grade != DFM_GRADE_4
                       && (active_fault_monitor == `DFM_CODE_NONE || ev.grade < fault_grade);

    assign clear_req = fault_clear_setting || clear_input_function_i;
    // cause gone first
    // a more severe fault arriving in the clear cycle wins over the clear
    assign fault_clr_ok = clear_req && active_fault_monitor != `DFM_CODE_NONE
                          && fault_grade != DFM_GRADE_1 && !servo_enable_i
                          && !cause_active_i && !new_fault;
    assign warn_clr_ok = clear_req && !new_warn;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            active_fault_monitor <= `DFM_CODE_NONE;
            // reset loads grade four; a clear leaves the grade as it was, so only the code says whether a fault is held
            fault_grade          <= DFM_GRADE_4;
        end else if (ce_i) begin
            if (new_fault) begin
                active_fault_monitor <= ev.code;
                fault_grade          <= ev.grade;
            end else if (fault_clr_ok) begin
                active_fault_monitor <= `DFM_CODE_NONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            active_warning_monitor <= `DFM_CODE_NONE;
        end else if (ce_i) begin
            if (new_warn) begin
                active_warning_monitor <= ev.code;
            end else if (warn_clr_ok) begin
                active_warning_monitor <= `DFM_CODE_NONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= DFM_ST_RDY;
        end else if (ce_i) begin
            unique case (state)
                // rdy and run follow servo enable while no fault is held
                DFM_ST_RDY, DFM_ST_RUN: begin
                    if (new_fault) begin
                        state <= DFM_ST_FAULT;
                    end else begin
                        state <= servo_enable_i ? DFM_ST_RUN : DFM_ST_RDY;
                    end
                end
                DFM_ST_FAULT: begin
                    if (fault_clr_ok) begin
                        state <= servo_enable_i ? DFM_ST_RUN : DFM_ST_RDY;
                    end
                end
                default: state <= DFM_ST_RDY;
            endcase
        end
    end
    assign drive_state_o = state;

    // never cleared by clear
    // newest entry at index zero, the oldest drops off the end
    generate
        for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_hist
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    f_code[i] <= `DFM_CODE_NONE;
                    f_stat[i] <= '0;
                    w_code[i] <= `DFM_CODE_NONE;
                    w_stat[i] <= '0;
                end else if (ce_i) begin
                    if (new_fault) begin
                        f_code[i] <= (i == 0) ? ev.code : f_code[(i == 0) ? 0 : i - 1];
                        f_stat[i] <= (i == 0) ? drive_status_i : f_stat[(i == 0) ? 0 : i - 1];
                    end
                    if (new_warn) begin
                        w_code[i] <= (i == 0) ? ev.code : w_code[(i == 0) ? 0 : i - 1];
                        w_stat[i] <= (i == 0) ? drive_status_i : w_stat[(i == 0) ? 0 : i - 1];
                    end
                end
            end
        end
    endgenerate

    // ---------------- axi4-lite ----------------
    logic       aw_held;
    logic       w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    logic        wr_clear;
    logic        wr_stat;
    logic        wr_mask;

    // one write in flight; a new address waits for the response
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_go   = aw_held && w_held && !s_axi_bvalid;
    assign wr_clear = wr_go && aw_addr == `DFM_OFF_CLEAR && w_strb[0];
    assign wr_stat  = wr_go && aw_addr == `DFM_OFF_IRQ_STAT && w_strb[0];
    assign wr_mask  = wr_go && aw_addr == `DFM_OFF_IRQ_MASK && w_strb[0];

    // write address holding
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (ce_i) begin
            if (wr_go) begin
                aw_held <= 1'b0;
            end else if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
        end
    end

    // write data holding
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (ce_i) begin
            if (wr_go) begin
                w_held <= 1'b0;
            end else if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // write response
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (ce_i) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                // unmapped or read-only targets answer slverr
                s_axi_bresp <= (aw_addr == `DFM_OFF_CLEAR || aw_addr == `DFM_OFF_IRQ_STAT
                                || aw_addr == `DFM_OFF_IRQ_MASK) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fault_clear_setting <= `DFM_CLEAR_RESET;
        end else if (ce_i) begin
            fault_clear_setting <= wr_clear ? w_data[0] : 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_mask <= `DFM_MASK_RESET;
        end else if (ce_i && wr_mask) begin
            irq_mask <= w_data[3:0];
        end
    end

    always_comb begin
        irq_set = '0;
        irq_set[`DFM_IRQ_FAULT]   = new_fault;
        irq_set[`DFM_IRQ_WARN]    = new_warn;
        irq_set[`DFM_IRQ_CLEARED] = fault_clr_ok;
        // tells software the clear came too early or cannot apply
        irq_set[`DFM_IRQ_REFUSED] = clear_req && !fault_clr_ok
                                    && active_fault_monitor != `DFM_CODE_NONE;
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_stat <= '0;
        end else if (ce_i) begin
            irq_stat <= (irq_stat & ~(wr_stat ? w_data[3:0] : 4'h0)) | irq_set;
        end
    end
    assign irq_o = |(irq_stat & irq_mask);

    // read side
    logic [31:0] rd_val;
    logic        rd_ok;
    logic [11:0] hidx;
    logic [31:0] hist_rd [2*HIST_DEPTH];

    // history words: faults first, then warnings, newest first
    generate
        for (genvar j = 0; j < HIST_DEPTH; j++) begin : g_hist_rd
            assign hist_rd[j]              = 32'({f_stat[j], f_code[j]});
            assign hist_rd[j + HIST_DEPTH] = 32'({w_stat[j], w_code[j]});
        end
    endgenerate

    always_comb begin
        rd_val = '0;
        rd_ok  = 1'b1;
        hidx   = s_axi_araddr - `DFM_OFF_HIST_BASE;
        unique case (s_axi_araddr)
            `DFM_OFF_CLEAR:     rd_val = {31'h0, fault_clear_setting};
            `DFM_OFF_ACT_FAULT: rd_val = {24'h0, active_fault_monitor};
            `DFM_OFF_ACT_WARN:  rd_val = {24'h0, active_warning_monitor};
            `DFM_OFF_STATUS:    rd_val = {27'h0, fault_grade, state};
            `DFM_OFF_IRQ_STAT:  rd_val = {28'h0, irq_stat};
            `DFM_OFF_IRQ_MASK:  rd_val = {28'h0, irq_mask};
            // unmapped reads answer slverr with zero data
            default: begin
                rd_ok = 1'b0;
                if (s_axi_araddr >= `DFM_OFF_HIST_BASE && hidx[1:0] == 2'h0
                    && hidx[11:2] < 10'(2 * HIST_DEPTH)) begin
                    rd_ok  = 1'b1;
                    rd_val = hist_rd[hidx[5:2]];
                end
            end
        endcase
    end

    // reads are refused while a response still stands
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= 2'h0;
        end else if (ce_i) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_val : 32'h0;
                s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ===== verilog/dfm_defines.svh
// register offsets, field positions, reset values and codes for the fault manager
`ifndef DFM_DEFINES_SVH
`define DFM_DEFINES_SVH
`define DFM_OFF_CLEAR      12'h000
`define DFM_OFF_ACT_FAULT  12'h004
`define DFM_OFF_ACT_WARN   12'h008
`define DFM_OFF_STATUS     12'h00c
`define DFM_OFF_IRQ_STAT   12'h010
`define DFM_OFF_IRQ_MASK   12'h014
`define DFM_OFF_HIST_BASE  12'h040
`define DFM_CLEAR_RESET    1'b0
`define DFM_MASK_RESET     4'h0
`define DFM_CODE_NONE      8'h00
`define DFM_CODE_PARAM_IO  8'h01
`define DFM_CODE_PARAM_CHK 8'h02
`define DFM_CODE_ADC_REF   8'h03
`define DFM_IRQ_FAULT      0
`define DFM_IRQ_WARN       1
`define DFM_IRQ_CLEARED    2
`define DFM_IRQ_REFUSED    3
`endif

// ===== verilog/dfm_pkg.sv
// types shared by the fault manager
package dfm_pkg;
    typedef enum logic [1:0] {
        DFM_GRADE_1 = 2'h0,
        DFM_GRADE_2 = 2'h1,
        DFM_GRADE_3 = 2'h2,
        DFM_GRADE_4 = 2'h3
    } dfm_grade_t;

    typedef struct packed {
        logic       valid;
        dfm_grade_t grade;
        logic [7:0] code;
    } dfm_event_t;

    typedef enum logic [2:0] {
        DFM_ST_RDY   = 3'b001,
        DFM_ST_RUN   = 3'b010,
        DFM_ST_FAULT = 3'b100
    } dfm_state_t;
endpackage

// ===== tb/dfm_fault_manager_chk.sv
// port checker for the fault manager
`timescale 1ns/1ns
module dfm_fault_manager_chk (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // watched inputs
    input wire logic       mem_fail_i,
    input wire logic       param_check_fail_i,
    input wire logic       adc_ref_bad_i,
    input wire logic       servo_enable_i,
    input wire logic       cause_active_i,
    // watched outputs
    input wire logic [2:0] drive_state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // cycles since a grade-one source was first seen, saturating
    logic [1:0] g1_age;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            g1_age <= 2'h0;
        end else if (g1_age != 2'h3 && (g1_age != 2'h0 || mem_fail_i || param_check_fail_i
                     || adc_ref_bad_i)) begin
            g1_age <= g1_age + 2'h1;
        end
    end

    sequence s_left;
        drive_state_o == 3'b100 ##1 drive_state_o != 3'b100;
    endsequence
    property p_onehot; $onehot(drive_state_o); endproperty
    property p_raise_mem; mem_fail_i |-> ##[1:3] drive_state_o == 3'b100; endproperty
    property p_raise_par; param_check_fail_i |-> ##[1:3] drive_state_o == 3'b100; endproperty
    property p_raise_adc; adc_ref_bad_i |-> ##[1:3] drive_state_o == 3'b100; endproperty
    property p_sticky; g1_age == 2'h3 |-> drive_state_o == 3'b100; endproperty
    property p_hold_en;
        drive_state_o == 3'b100 && servo_enable_i && $past(servo_enable_i)
            && $past(servo_enable_i, 2) |=> drive_state_o == 3'b100;
    endproperty
    property p_hold_cause;
        drive_state_o == 3'b100 && cause_active_i && $past(cause_active_i)
            && $past(cause_active_i, 2) |=> drive_state_o == 3'b100;
    endproperty
    property p_leave;
        s_left ##0 (!servo_enable_i && !$past(servo_enable_i)) |-> drive_state_o == 3'b001;
    endproperty

    a_onehot: assert property (p_onehot) else $error("state not one-hot");
    a_raise_mem: assert property (p_raise_mem) else $error("memory fault missed");
    a_raise_par: assert property (p_raise_par) else $error("check fault missed");
    a_raise_adc: assert property (p_raise_adc) else $error("reference fault missed");
    a_sticky: assert property (p_sticky) else $error("grade one fault left");
    a_hold_en: assert property (p_hold_en) else $error("cleared while enabled");
    a_hold_cause: assert property (p_hold_cause) else $error("cleared with cause");
    a_leave: assert property (p_leave) else $error("not ready after clear");
endmodule

// ===== tb/dfm_host_model.sv
// host controller model driving enable and clear terminals
`timescale 1ns/1ns
module dfm_host_model (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // bench commands
    input  wire logic run_i,
    input  wire logic clr_req_i,
    input  wire logic keep_en_i,
    input  wire logic slow_i,
    // terminals
    output logic      servo_enable_o,
    output logic      clear_input_function_o,
    output logic      busy_o
);
    logic [1:0] step;
    logic [2:0] wait_cnt;
    assign busy_o = step != 2'h0;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            step <= 2'h0;
            wait_cnt <= 3'h0;
            servo_enable_o <= 1'b0;
            clear_input_function_o <= 1'b0;
        end else begin
            case (step)
                2'h0: begin
                    servo_enable_o <= run_i;
                    wait_cnt <= slow_i ? 3'h4 : 3'h0;
                    if (clr_req_i) step <= 2'h1;
                end
                // enable follows keep_en_i while wait_cnt counts down first
                2'h1: begin
                    servo_enable_o <= keep_en_i;
                    wait_cnt <= wait_cnt - 3'h1;
                    if (wait_cnt == 3'h0) step <= 2'h2;
                end
                2'h2: begin
                    clear_input_function_o <= 1'b1;
                    step <= 2'h3;
                end
                default: begin
                    clear_input_function_o <= 1'b0;
                    step <= 2'h0;
                end
            endcase
        end
    end
endmodule

// ===== tb/dfm_fault_manager_test.sv
// self-checking bench for the fault manager
`timescale 1ns/1ns
`include "dfm_defines.svh"
module dfm_fault_manager_test;
    import dfm_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, irq_o;
    dfm_event_t event_i = '0;
    logic cause_active_i = 1'b0, mem_fail_i = 1'b0, param_check_fail_i = 1'b0;
    logic adc_ref_bad_i = 1'b0, servo_enable_i, clear_input_function_i;
    logic [15:0] drive_status_i = '0;
    logic [2:0] drive_state_o;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'hfd0d;
    logic [31:0] hw [5];
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic run = 1'b0, clr_req = 1'b0, keep_en = 1'b0, slow = 1'b0, busy;
    logic [7:0] c;
    int miscompares = 0, total_checks = 0;
    always #2 clk_i = ~clk_i;

    dfm_fault_manager dut (.clk_i, .rst_n_i, .ce_i, .event_i, .cause_active_i, .mem_fail_i,
        .param_check_fail_i, .adc_ref_bad_i, .drive_status_i, .servo_enable_i,
        .clear_input_function_i, .drive_state_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    dfm_host_model host (.clk_i, .rst_n_i, .run_i(run), .clr_req_i(clr_req), .keep_en_i(keep_en),
        .slow_i(slow), .servo_enable_o(servo_enable_i),
        .clear_input_function_o(clear_input_function_i), .busy_o(busy));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] hist_word(input logic [15:0] s, input logic [7:0] cd);
        return {8'h00, s, cd};
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic rst();
        rst_n_i <= 1'b0;
        cyc(4);
        rst_n_i <= 1'b1;
    endtask
    // bounded wait ran out: count it and stop
    task automatic bail(input int n);
        if (n == 50) begin
            miscompares++;
            final_report();
        end
    endtask
    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        bail(n);
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        bail(n);
        chk($sformatf("reg %h", a), e, s_axi_rdata);
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    task automatic fire(input dfm_grade_t g, input logic [7:0] cd, input logic [15:0] s);
        event_i <= {1'b1, g, cd};
        drive_status_i <= s;
        @(posedge clk_i);
        event_i <= '0;
        cyc(3);
    endtask
    task automatic pin_clear(input logic k, input logic s);
        int n;
        keep_en <= k;
        slow <= s;
        clr_req <= 1'b1;
        @(posedge clk_i);
        clr_req <= 1'b0;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (!busy) break;
        end
        bail(n);
        cyc(3);
    endtask

    initial begin
        rst();
        chk("state", 3'b001, drive_state_o);
        rd_chk(`DFM_OFF_CLEAR, 32'h0, 2'h0);
        rd_chk(`DFM_OFF_IRQ_MASK, 32'h0, 2'h0);
        rd_chk(12'h03c, 32'h0, 2'h2);
        wr_chk(`DFM_OFF_ACT_FAULT, 32'hff, 2'h2);
        run <= 1'b1;
        cyc(3);
        chk("run", 3'b010, drive_state_o);
        fire(DFM_GRADE_4, 8'h21, 16'h1234);
        chk("irq masked", 1'b0, irq_o);
        wr_chk(`DFM_OFF_IRQ_MASK, 32'hf, 2'h0);
        cyc(1);
        chk("irq", 1'b1, irq_o);
        rd_chk(`DFM_OFF_ACT_WARN, 32'h21, 2'h0);
        chk("warn run", 3'b010, drive_state_o);
        pin_clear(1'b1, 1'b0);
        rd_chk(`DFM_OFF_ACT_WARN, 32'h0, 2'h0);
        wr_chk(`DFM_OFF_IRQ_STAT, 32'hf, 2'h0);
        rd_chk(`DFM_OFF_IRQ_STAT, 32'h0, 2'h0);
        chk("irq off", 1'b0, irq_o);
        rd_chk(`DFM_OFF_HIST_BASE + 12'h014, hist_word(16'h1234, 8'h21), 2'h0);
        run <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            c = seed[15:8] | 8'h10;
            hw[i] = hist_word(seed[31:16], c);
            fire(seed[0] ? DFM_GRADE_2 : DFM_GRADE_3, c, seed[31:16]);
            chk("fault", 3'b100, drive_state_o);
            if (i == 0) begin
                cause_active_i <= 1'b1;
                pin_clear(1'b0, 1'b0);
                chk("cause held", 3'b100, drive_state_o);
                cause_active_i <= 1'b0;
                pin_clear(1'b1, 1'b1);
                chk("enable held", 3'b100, drive_state_o);
            end
            if (i % 2 == 1) begin
                wr_chk(`DFM_OFF_CLEAR, 32'h1, 2'h0);
                cyc(3);
            end else begin
                pin_clear(1'b0, 1'b0);
            end
            chk("ready", 3'b001, drive_state_o);
            rd_chk(`DFM_OFF_ACT_FAULT, 32'h0, 2'h0);
        end
        rd_chk(`DFM_OFF_CLEAR, 32'h0, 2'h0);
        rd_chk(`DFM_OFF_IRQ_STAT, 32'hd, 2'h0);
        for (int k = 0; k < 5; k++) begin
            rd_chk(`DFM_OFF_HIST_BASE + 12'(4 * k), hw[4 - k], 2'h0);
        end
        run <= 1'b1;
        cyc(3);
        chk("run again", 3'b010, drive_state_o);
        for (int k = 0; k < 3; k++) begin
            {adc_ref_bad_i, param_check_fail_i, mem_fail_i} <= 3'b001 << k;
            cyc(2);
            {adc_ref_bad_i, param_check_fail_i, mem_fail_i} <= 3'b000;
            cyc(3);
            rd_chk(`DFM_OFF_ACT_FAULT, 32'(k + 1), 2'h0);
            rd_chk(`DFM_OFF_STATUS, 32'h4, 2'h0);
            pin_clear(1'b0, 1'b0);
            wr_chk(`DFM_OFF_CLEAR, 32'h1, 2'h0);
            cyc(3);
            chk("grade one", 3'b100, drive_state_o);
            rd_chk(`DFM_OFF_ACT_FAULT, 32'(k + 1), 2'h0);
            if (k > 0) rd_chk(`DFM_OFF_IRQ_STAT, 32'h9, 2'h0);
            rst();
        end
        final_report();
    end
endmodule

bind dfm_fault_manager dfm_fault_manager_chk u_chk (.clk_i, .rst_n_i, .mem_fail_i,
    .param_check_fail_i, .adc_ref_bad_i, .servo_enable_i, .cause_active_i, .drive_state_o);
